// ==== src/seee_enum.sv ====
// feature-query enumeration and enclave instruction gating, per thread;
// assumes query, register write and instruction ports are synchronous.
`timescale 1ns/1ps

module seee_enum
	import seee_pkg::*;
#(
	parameter int                THREADS        = 2,
	parameter logic [THREADS-1:0] THREAD_SUPPORT = '1,
	parameter logic              HAS_GEN1       = 1'b1,
	parameter logic              HAS_GEN2       = 1'b1,
	parameter logic              HAS_VIRT       = 1'b0,
	parameter logic              HAS_TRACK      = 1'b0,
	parameter logic [31:0]       MISC_VECTOR    = 32'h0000_0000,
	parameter logic [7:0]        MAX_EXP_LEGACY = 8'h1f,
	parameter logic [7:0]        MAX_EXP_LONG   = 8'h24,
	parameter logic [31:0]       ATTR_MASK0     = 32'h0000_0036,
	parameter logic [31:0]       ATTR_MASK1     = 32'h0000_0000,
	parameter logic [31:0]       ATTR_MASK2     = 32'h0000_0007,
	parameter logic [31:0]       ATTR_MASK3     = 32'h0000_0000,
	parameter int                SECTIONS       = 4,
	parameter int                TW             = 1,
	parameter int                AW             = 2,
	parameter int                SW             = 3
)
(
	input  wire logic                  mclk,
	input  wire logic                  reset,
	input  wire logic                  clk_en,
	input  wire logic                  query_valid,
	input  wire logic [TW-1:0]         query_thread,
	input  wire logic [31:0]           query_leaf,
	input  wire logic [31:0]           query_subleaf,
	output logic                       result_valid_q,
	output logic      [31:0]           res_eax_q,
	output logic      [31:0]           res_ebx_q,
	output logic      [31:0]           res_ecx_q,
	output logic      [31:0]           res_edx_q,
	input  wire logic                  msr_wr_valid,
	input  wire logic [TW-1:0]         msr_wr_thread,
	input  wire logic [31:0]           msr_wr_data,
	output logic                       msr_wr_fault_q,
	output logic      [THREADS-1:0]    opted_in_q,
	input  wire logic                  sect_wr_valid,
	input  wire logic [AW-1:0]         sect_wr_index,
	input  wire logic [SECT_FIELD_WIDTH-1:0] sect_wr_base,
	input  wire logic [SECT_FIELD_WIDTH-1:0] sect_wr_size,
	output logic                       sect_wr_fault_q,
	output logic      [SW-1:0]         sect_count_q,
	input  wire logic                  instr_valid,
	input  wire logic [TW-1:0]         instr_thread,
	input  wire logic                  instr_extra_ud,
	output logic                       gate_ok_q,
	output logic                       gate_ud_q,
	output logic                       gate_gp_q
);

	// ----------------------------------------------------------------
	// elaboration checks and helpers
	// ----------------------------------------------------------------
	if (THREADS < 1 || TW < 1 || (1 << TW) < THREADS || SECTIONS < 1
		|| (1 << AW) < SECTIONS || (1 << SW) <= SECTIONS)
	begin : bad_cfg
		$error("seee_enum: thread or section widths too small");
	end

	// out-of-range thread indices read as not supported / not opted in
	function automatic logic thr_bit(input logic [THREADS-1:0] v,
		input logic [TW-1:0] t);
		thr_bit = (int'(t) < THREADS) ? v[t] : 1'b0;
	endfunction : thr_bit

	function automatic logic is_leaf(input logic [31:0] leaf,
		input logic [31:0] sub, input logic [31:0] l,
		input logic [31:0] s);
		is_leaf = (leaf == l) && (sub == s);
	endfunction : is_leaf

	logic [THREADS-1:0] fc_lock_q, fc_lock_d;
	logic [THREADS-1:0] fc_optin_q, fc_optin_d;
	logic [THREADS-1:0] opted_in_d;
	logic               msr_wr_fault_d;
	logic               sect_wr_fault_d;
	logic [SW-1:0]      sect_count_d;
	logic               mem_wr_en;
	logic [2*SECT_FIELD_WIDTH-1:0] mem_rd_data;
	logic               q1_valid_q, q1_valid_d;
	seee_kind_e         q1_kind_q, q1_kind_d;
	logic               q1_sup_q, q1_sup_d;
	logic               result_valid_d;
	logic [31:0]        res_eax_d, res_ebx_d, res_ecx_d, res_edx_d;
	logic               gate_ok_d, gate_ud_d, gate_gp_d;
	logic               q_sup, q_opt, i_sup, i_opt;
	logic [31:0]        sect_rel;

	// ----------------------------------------------------------------
	// feature control and section configuration
	// ----------------------------------------------------------------
	// once locked, a thread's control bits refuse every write
	always_comb
	begin
		fc_lock_d       = fc_lock_q;
		fc_optin_d      = fc_optin_q;
		sect_count_d    = sect_count_q;
		{msr_wr_fault_d, sect_wr_fault_d, mem_wr_en} = 3'h0;
		if (msr_wr_valid)
		begin
			if (!(int'(msr_wr_thread) < THREADS)
				|| thr_bit(fc_lock_q, msr_wr_thread)
				|| (msr_wr_data[FC_OPTIN_POS]
				&& !thr_bit(THREAD_SUPPORT, msr_wr_thread)))
				msr_wr_fault_d = 1'b1;
			else
			begin
				fc_lock_d[msr_wr_thread]  = msr_wr_data[FC_LOCK_POS];
				fc_optin_d[msr_wr_thread] = msr_wr_data[FC_OPTIN_POS];
			end
		end
		// sections are firmware setup: frozen once any thread locks
		if (sect_wr_valid)
		begin
			if ((|fc_lock_q) || !(int'(sect_wr_index) < SECTIONS))
				sect_wr_fault_d = 1'b1;
			else
			begin
				mem_wr_en = 1'b1;
				if (SW'(sect_wr_index) >= sect_count_q)
					sect_count_d = SW'(sect_wr_index) + SW'(1);
			end
		end
		opted_in_d = fc_lock_d & fc_optin_d;
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			{fc_lock_q, fc_optin_q} <= {2*THREADS{FC_RESET}};
			opted_in_q      <= '0;
			{msr_wr_fault_q, sect_wr_fault_q} <= 2'h0;
			sect_count_q    <= '0;
		end
		else if (clk_en)
		begin
			fc_lock_q       <= fc_lock_d;
			fc_optin_q      <= fc_optin_d;
			opted_in_q      <= opted_in_d;
			msr_wr_fault_q  <= msr_wr_fault_d;
			sect_wr_fault_q <= sect_wr_fault_d;
			sect_count_q    <= sect_count_d;
		end
	end

	seee_sect_mem #(.WIDTH(2*SECT_FIELD_WIDTH), .DEPTH(SECTIONS), .AW(AW))
	u_sect_mem (
		.mclk      (mclk),
		.reset     (reset),
		.clk_en    (clk_en),
		.wr_en     (mem_wr_en),
		.wr_addr   (sect_wr_index),
		.wr_data   ({sect_wr_size, sect_wr_base}),
		.rd_addr   (AW'(query_subleaf - SUBLEAF_SECT_FIRST)),
		.rd_data_q (mem_rd_data)
	);

	// ----------------------------------------------------------------
	// query stage one: classify the request
	// ----------------------------------------------------------------
	// opt-in steers only which sections exist, never a result bit
	always_comb
	begin
		q_sup      = thr_bit(THREAD_SUPPORT, query_thread);
		q_opt      = thr_bit(opted_in_q, query_thread);
		sect_rel   = query_subleaf - SUBLEAF_SECT_FIRST;
		q1_valid_d = query_valid;
		q1_sup_d   = q_sup;
		q1_kind_d  = K_NONE;
		if (is_leaf(query_leaf, query_subleaf, LEAF_EXT_FEAT, SUBLEAF_CAP))
			q1_kind_d = K_FEAT;
		else if (query_leaf == LEAF_ENCLAVE && q_sup)
		begin
			if (query_subleaf == SUBLEAF_CAP)
				q1_kind_d = K_CAP;
			else if (query_subleaf == SUBLEAF_ATTR)
				q1_kind_d = K_ATTR;
			else if (q_opt && sect_rel < 32'(sect_count_q))
				q1_kind_d = K_SECT;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			{q1_valid_q, q1_sup_q} <= 2'h0;
			q1_kind_q  <= K_NONE;
		end
		else if (clk_en)
		begin
			{q1_valid_q, q1_sup_q} <= {q1_valid_d, q1_sup_d};
			q1_kind_q  <= q1_kind_d;
		end
	end

	// ----------------------------------------------------------------
	// query stage two: build the four result words
	// ----------------------------------------------------------------
	// words are constants or parameters, except section words, which are read from the section memory that section writes fill
	always_comb
	begin
		result_valid_d = q1_valid_q;
		{res_eax_d, res_ebx_d, res_ecx_d, res_edx_d} = '0;
		unique case (q1_kind_q)
			K_NONE: ;
			K_FEAT:
				res_ebx_d[EXT_SUPPORT_POS] = q1_sup_q;
			K_CAP:
			begin
				res_eax_d[CAP_GEN1_POS]  = HAS_GEN1;
				res_eax_d[CAP_GEN2_POS]  = HAS_GEN2;
				res_eax_d[CAP_VIRT_POS]  = HAS_VIRT;
				res_eax_d[CAP_TRACK_POS] = HAS_TRACK;
				res_ebx_d = MISC_VECTOR;
				res_edx_d = {16'h0000, MAX_EXP_LONG,
					MAX_EXP_LEGACY};
			end
			K_ATTR:
			begin
				res_eax_d = ATTR_MASK0;
				res_ebx_d = ATTR_MASK1;
				res_ecx_d = ATTR_MASK2;
				res_edx_d = ATTR_MASK3;
			end
			K_SECT:
			begin
				res_eax_d = {mem_rd_data[SECT_HALF_WIDTH-1:0], 8'h00,
					SECT_TYPE_MEM};
				res_ebx_d = {12'h000,
					mem_rd_data[SECT_FIELD_WIDTH-1:SECT_HALF_WIDTH]};
				res_ecx_d = {mem_rd_data[SECT_FIELD_WIDTH+SECT_HALF_WIDTH-1:
					SECT_FIELD_WIDTH], 8'h00, SECT_PROT_CI};
				res_edx_d = {12'h000,
					mem_rd_data[2*SECT_FIELD_WIDTH-1:
					SECT_FIELD_WIDTH+SECT_HALF_WIDTH]};
			end
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			result_valid_q <= 1'b0;
			{res_eax_q, res_ebx_q, res_ecx_q, res_edx_q} <= '0;
		end
		else if (clk_en)
		begin
			result_valid_q <= result_valid_d;
			{res_eax_q, res_ebx_q} <= {res_eax_d, res_ebx_d};
			{res_ecx_q, res_edx_q} <= {res_ecx_d, res_edx_d};
		end
	end

	// ----------------------------------------------------------------
	// enclave instruction gating
	// ----------------------------------------------------------------
	// decided from the registered opted_in_q, so a lock counts from the cycle after its write
	always_comb
	begin
		i_sup     = thr_bit(THREAD_SUPPORT, instr_thread);
		i_opt     = thr_bit(opted_in_q, instr_thread);
		{gate_ok_d, gate_ud_d, gate_gp_d} = 3'h0;
		if (instr_valid)
		begin
			if (!i_sup || instr_extra_ud)
				gate_ud_d = 1'b1;
			else if (!i_opt)
				gate_gp_d = 1'b1;
			else
				gate_ok_d = 1'b1;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
			{gate_ok_q, gate_ud_q, gate_gp_q} <= 3'h0;
		else if (clk_en)
			{gate_ok_q, gate_ud_q, gate_gp_q} <=
				{gate_ok_d, gate_ud_d, gate_gp_d};
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	sequence taken_s(logic [31:0] l, logic [31:0] s);
		clk_en && query_valid && query_leaf == l && query_subleaf == s;
	endsequence
	feat_flag_a: assert property (taken_s(LEAF_EXT_FEAT, SUBLEAF_CAP) ##1
		clk_en |=> result_valid_q && res_ebx_q[EXT_SUPPORT_POS] ==
		thr_bit(THREAD_SUPPORT, $past(query_thread, 2)))
		else $error("support flag wrong");
	cap_rsvd_a: assert property (taken_s(LEAF_ENCLAVE, SUBLEAF_CAP) ##1
		clk_en |=> res_eax_q[4:2] == 3'h0 && res_eax_q[31:7] == '0
		&& res_ecx_q == '0 && res_edx_q[31:16] == 16'h0000)
		else $error("capability reserved bits set");
	no_support_a: assert property (clk_en && query_valid
		&& query_leaf == LEAF_ENCLAVE && !thr_bit(THREAD_SUPPORT,
		query_thread) ##1 clk_en |=> res_eax_q == '0 && res_ebx_q == '0
		&& res_ecx_q == '0 && res_edx_q == '0)
		else $error("unsupported leaf not zero");
	sect_zero_a: assert property (clk_en && query_valid
		&& query_leaf == LEAF_ENCLAVE && query_subleaf > SUBLEAF_ATTR
		&& !(sect_rel < 32'(sect_count_q) && q_opt) ##1 clk_en
		|=> res_eax_q[3:0] == SECT_TYPE_INVALID && res_ebx_q == '0
		&& res_ecx_q == '0 && res_edx_q == '0)
		else $error("invalid sub-leaf not zero");
	sect_type_a: assert property (clk_en && q1_kind_q == K_SECT
		|=> res_eax_q[3:0] == SECT_TYPE_MEM && res_eax_q[11:4] == 8'h00
		&& res_ecx_q[3:0] == SECT_PROT_CI && res_ebx_q[31:20] == '0)
		else $error("section fields wrong");
	gate_ud_a: assert property (clk_en && instr_valid
		&& (instr_extra_ud || !thr_bit(THREAD_SUPPORT, instr_thread))
		|=> gate_ud_q && !gate_gp_q && !gate_ok_q)
		else $error("invalid opcode not raised");
	gate_gp_a: assert property (clk_en && instr_valid && !instr_extra_ud
		&& thr_bit(THREAD_SUPPORT, instr_thread)
		&& !(thr_bit(fc_lock_q, instr_thread)
		&& thr_bit(fc_optin_q, instr_thread)) |=> gate_gp_q && !gate_ok_q)
		else $error("protection fault not raised");
	lock_hold_a: assert property (clk_en && msr_wr_valid
		&& thr_bit(fc_lock_q, msr_wr_thread) |=> msr_wr_fault_q
		&& $stable(fc_lock_q) && $stable(fc_optin_q) ##1 fc_lock_q != '0)
		else $error("locked control bits changed");
endmodule : seee_enum

// ==== src/seee_pkg.sv ====
// constants, field layout and types of the enclave enablement and
// enumeration block; assumes one core clock and a synchronous reset.
//
// Overview of operation
// - leaf 07H sub 0 EBX bit 2 reports support
// - supported threads answer leaf 12H sub-leaves
// - opted in only when lock and opt-in set
// - opt-in state shows only in which section sub-leaves are valid
// - gating: unsupported opcode fault, unopted protection fault
// - per-instruction conditions still raise opcode fault
// - valid sub-leaves follow opt-in and configuration
// - leaf 12H results kept per hardware thread
// - sub-leaves 0, 1 and sections carry content
// - sub 0 EAX generation flags, reserved bits zero
// - sub 0 EAX bits 5, 6 oversubscription leaves
// - sub 0 EBX misc vector, ECX zero
// - sub 0 EDX 7:0 legacy size exponent
// - sub 0 EDX 15:8 long exponent, rest zero
// - sub 1 words are attribute settable masks
// - invalid sub-leaves return all four zero
// - section EAX 3:0 type, 0 invalid, 1 section
// - section base bits 51:12 in EAX, EBX
// - section size in ECX, EDX; ECX 3:0 protection

package seee_pkg;

	// ----------------------------------------------------------------
	// leaf and sub-leaf codes
	// ----------------------------------------------------------------
	localparam logic [31:0] LEAF_EXT_FEAT      = 32'h0000_0007;
	localparam logic [31:0] LEAF_ENCLAVE       = 32'h0000_0012;
	localparam logic [31:0] SUBLEAF_CAP        = 32'h0000_0000;
	localparam logic [31:0] SUBLEAF_ATTR       = 32'h0000_0001;
	localparam logic [31:0] SUBLEAF_SECT_FIRST = 32'h0000_0002;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int EXT_SUPPORT_POS  = 2;
	localparam int FC_LOCK_POS      = 0;
	localparam int FC_OPTIN_POS     = 18;
	localparam int CAP_GEN1_POS     = 0;
	localparam int CAP_GEN2_POS     = 1;
	localparam int CAP_VIRT_POS     = 5;
	localparam int CAP_TRACK_POS    = 6;
	localparam int SECT_HALF_WIDTH  = 20;
	localparam int SECT_FIELD_WIDTH = 40;

	// ----------------------------------------------------------------
	// codes, reset values and timing counts
	// ----------------------------------------------------------------
	localparam logic [3:0] SECT_TYPE_INVALID = 4'h0;
	localparam logic [3:0] SECT_TYPE_MEM     = 4'h1;
	localparam logic [3:0] SECT_PROT_CI      = 4'h1;
	localparam logic       FC_RESET          = 1'b0;
	localparam int         RESULT_LATENCY    = 2;
	localparam int         GATE_LATENCY      = 1;

	// kind of answer decided in the first query stage
	typedef enum logic [4:0]
	{
		K_NONE = 5'h01,
		K_FEAT = 5'h02,
		K_CAP  = 5'h04,
		K_ATTR = 5'h08,
		K_SECT = 5'h10
	} seee_kind_e;

endpackage : seee_pkg

// ==== src/seee_sect_mem.sv ====
// small memory holding the configured protected memory sections;
// assumes the owner drives one write and one read port per cycle.
`timescale 1ns/1ps

module seee_sect_mem
	import seee_pkg::*;
#(
	parameter int WIDTH = 80,
	parameter int DEPTH = 4,
	parameter int AW    = 2
)
(
	input  wire logic             mclk,
	input  wire logic             reset,
	input  wire logic             clk_en,
	input  wire logic             wr_en,
	input  wire logic [AW-1:0]    wr_addr,
	input  wire logic [WIDTH-1:0] wr_data,
	input  wire logic [AW-1:0]    rd_addr,
	output logic      [WIDTH-1:0] rd_data_q
);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [WIDTH-1:0] rd_data_d;

	// ----------------------------------------------------------------
	// storage and registered read
	// ----------------------------------------------------------------
	// out-of-range reads give zero so a stray index shows no stale data
	always_comb
	begin
		rd_data_d = '0;
		if (int'(rd_addr) < DEPTH)
			rd_data_d = mem_q[rd_addr];
	end

	// array kept without reset; an unwritten entry below the section count is still read out as a section
	always_ff @(posedge mclk)
	begin
		if (clk_en && wr_en && int'(wr_addr) < DEPTH)
			mem_q[wr_addr] <= wr_data;
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
			rd_data_q <= '0;
		else if (clk_en)
			rd_data_q <= rd_data_d;
	end

endmodule : seee_sect_mem

// ==== verification/seee_fw_model.sv ====
// firmware and system software side: feature queries, control writes,
// section setup and enclave instructions; assumes mclk from the bench.
`timescale 1ns/1ps

module seee_fw_model
	import seee_pkg::*;
(
	input  wire logic        mclk,
	output logic             clk_en,
	output logic             query_valid,
	output logic [0:0]       query_thread,
	output logic [31:0]      query_leaf,
	output logic [31:0]      query_subleaf,
	input  wire logic        result_valid_q,
	input  wire logic [31:0] res_eax_q,
	input  wire logic [31:0] res_ebx_q,
	input  wire logic [31:0] res_ecx_q,
	input  wire logic [31:0] res_edx_q,
	output logic             msr_wr_valid,
	output logic [0:0]       msr_wr_thread,
	output logic [31:0]      msr_wr_data,
	input  wire logic        msr_wr_fault_q,
	output logic             sect_wr_valid,
	output logic [1:0]       sect_wr_index,
	output logic [39:0]      sect_wr_base,
	output logic [39:0]      sect_wr_size,
	input  wire logic        sect_wr_fault_q,
	output logic             instr_valid,
	output logic [0:0]       instr_thread,
	output logic             instr_extra_ud,
	input  wire logic        gate_ok_q,
	input  wire logic        gate_ud_q,
	input  wire logic        gate_gp_q
);
	// ----------------------------------------------------------------
	// idle values
	// ----------------------------------------------------------------
	initial
	begin
		{clk_en, query_valid, msr_wr_valid} = 3'h1 << 2;
		{query_thread, query_leaf, query_subleaf} = '0;
		{msr_wr_thread, msr_wr_data, sect_wr_valid} = '0;
		{sect_wr_index, sect_wr_base, sect_wr_size} = '0;
		{instr_valid, instr_thread, instr_extra_ud} = '0;
	end

	// ----------------------------------------------------------------
	// access tasks
	// ----------------------------------------------------------------
	// words come back as {edx,ecx,ebx,eax}; x when no answer arrives
	task query(input logic t, input logic [31:0] l, input logic [31:0] s,
		output logic [127:0] r);
		r = 'x;
		@(posedge mclk);
		query_valid   <= 1'b1;
		query_thread  <= t;
		query_leaf    <= l;
		query_subleaf <= s;
		@(posedge mclk);
		query_valid   <= 1'b0;
		query_leaf    <= ~l; // released lines must not keep their value
		query_subleaf <= ~s;
		repeat (4)
		begin
			@(posedge mclk);
			#1;
			if (result_valid_q === 1'b1)
				r = {res_edx_q, res_ecx_q, res_ebx_q, res_eax_q};
		end
	endtask : query

	// firmware opt-in and lock write, done before any enabling
	task msr(input logic t, input logic [31:0] d, output logic f);
		@(posedge mclk);
		msr_wr_valid  <= 1'b1;
		msr_wr_thread <= t;
		msr_wr_data   <= d;
		@(posedge mclk);
		msr_wr_valid <= 1'b0;
		msr_wr_data  <= ~d;
		#1;
		f = msr_wr_fault_q;
	endtask : msr

	task sect(input logic [1:0] i, input logic [39:0] b,
		input logic [39:0] z, output logic f);
		@(posedge mclk);
		sect_wr_valid <= 1'b1;
		sect_wr_index <= i;
		sect_wr_base  <= b;
		sect_wr_size  <= z;
		@(posedge mclk);
		sect_wr_valid <= 1'b0;
		sect_wr_base  <= ~b;
		#1;
		f = sect_wr_fault_q;
	endtask : sect

	// g is {ok, ud, gp}
	task instr(input logic t, input logic x, output logic [2:0] g);
		@(posedge mclk);
		instr_valid    <= 1'b1;
		instr_thread   <= t;
		instr_extra_ud <= x;
		@(posedge mclk);
		instr_valid <= 1'b0;
		#1;
		g = {gate_ok_q, gate_ud_q, gate_gp_q};
	endtask : instr

	// drop or raise the clock enable at the next edge
	task enable(input logic e);
		@(posedge mclk);
		clk_en <= e;
	endtask : enable

	// walk sections from sub-leaf 2 until the type reads invalid
	task walk(input logic t, output int n);
		logic [127:0] r;
		n = 0;
		query(t, LEAF_ENCLAVE, SUBLEAF_SECT_FIRST, r);
		while (r[3:0] === SECT_TYPE_MEM && n < 8)
		begin
			n++;
			query(t, LEAF_ENCLAVE, 32'(n + 2), r);
		end
	endtask : walk
endmodule : seee_fw_model

// ==== verification/testbench.sv ====
// self-checking bench for the enclave enumeration block; assumes the
// firmware model drives every request port of the design.
`timescale 1ns/1ps

module testbench;
	import seee_pkg::*;
	localparam logic [31:0]  MISC = 32'h0000_0003;
	localparam logic [127:0] CAP0 = {32'h241f, 32'h0, MISC, 32'h23};
	localparam logic [127:0] CAP1 = {32'h0, 32'h7, 32'h0, 32'h36};
	localparam logic [39:0]  B0 = 40'ha5_1234_5678;
	localparam logic [39:0]  Z0 = 40'h00_0000_1000;
	localparam logic [39:0]  B1 = 40'h0f_edcb_a987;
	localparam logic [39:0]  Z1 = 40'h00_0020_0000;

	logic        mclk, reset, clk_en, query_valid, result_valid_q;
	logic [0:0]  query_thread, msr_wr_thread, instr_thread;
	logic [31:0] query_leaf, query_subleaf, msr_wr_data;
	logic [31:0] res_eax_q, res_ebx_q, res_ecx_q, res_edx_q;
	logic        msr_wr_valid, msr_wr_fault_q, sect_wr_valid;
	logic        sect_wr_fault_q, instr_valid, instr_extra_ud;
	logic        gate_ok_q, gate_ud_q, gate_gp_q;
	logic [1:0]  opted_in_q, sect_wr_index;
	logic [39:0] sect_wr_base, sect_wr_size;
	logic [2:0]  sect_count_q;
	int          n_mismatch, tests_run, cycles;

	// thread 1 lacks support so both gating outcomes can be seen
	seee_enum #(.THREAD_SUPPORT(2'b01), .HAS_VIRT(1'b1),
		.MISC_VECTOR(MISC)) DUT (.mclk, .reset, .clk_en, .query_valid,
		.query_thread, .query_leaf, .query_subleaf, .result_valid_q,
		.res_eax_q, .res_ebx_q, .res_ecx_q, .res_edx_q, .msr_wr_valid,
		.msr_wr_thread, .msr_wr_data, .msr_wr_fault_q, .opted_in_q,
		.sect_wr_valid, .sect_wr_index, .sect_wr_base, .sect_wr_size,
		.sect_wr_fault_q, .sect_count_q, .instr_valid, .instr_thread,
		.instr_extra_ud, .gate_ok_q, .gate_ud_q, .gate_gp_q);

	seee_fw_model fw (.mclk, .clk_en, .query_valid, .query_thread,
		.query_leaf, .query_subleaf, .result_valid_q, .res_eax_q,
		.res_ebx_q, .res_ecx_q, .res_edx_q, .msr_wr_valid,
		.msr_wr_thread, .msr_wr_data, .msr_wr_fault_q, .sect_wr_valid,
		.sect_wr_index, .sect_wr_base, .sect_wr_size, .sect_wr_fault_q,
		.instr_valid, .instr_thread, .instr_extra_ud, .gate_ok_q,
		.gate_ud_q, .gate_gp_q);

	// ----------------------------------------------------------------
	// clock, watchdog and helpers
	// ----------------------------------------------------------------
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// the whole run needs about 134 cycles
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			n_mismatch++;
			close_out();
		end
	end

	task chk(input logic [127:0] got, input logic [127:0] exp,
		input string m);
		tests_run++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("BAD %0t %s", $time, m);
		end
	endtask : chk

	task close_out;
		$display("mismatches %0d checks %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : close_out

	// section words expected for a base and size
	function automatic logic [127:0] sx(input logic [39:0] b,
		input logic [39:0] z);
		return {12'h0, z[39:20], z[19:0], 8'h0, SECT_PROT_CI,
			12'h0, b[39:20], b[19:0], 8'h0, SECT_TYPE_MEM};
	endfunction : sx

	task chk_cap;
		logic [127:0] r;
		fw.query(1'b0, LEAF_ENCLAVE, SUBLEAF_CAP, r);
		chk(r, CAP0, "sub 0 words");
		fw.query(1'b0, LEAF_ENCLAVE, SUBLEAF_ATTR, r);
		chk(r, CAP1, "sub 1 masks");
	endtask : chk_cap

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		logic [127:0] r;
		logic         f;
		logic [2:0]   g;
		int           n;
		reset = 1'b1;
		repeat (16) @(posedge mclk);
		reset <= 1'b0;
		fw.query(1'b0, LEAF_EXT_FEAT, SUBLEAF_CAP, r);
		chk(r[34], 1'b1, "support flag");
		fw.query(1'b1, LEAF_EXT_FEAT, SUBLEAF_CAP, r);
		chk(r[34], 1'b0, "flag other thread");
		chk_cap();
		fw.query(1'b1, LEAF_ENCLAVE, SUBLEAF_CAP, r);
		chk(r, '0, "leaf on unsupported");
		fw.instr(1'b0, 1'b0, g);
		chk(g, 3'b001, "gp before opt-in");
		fw.instr(1'b1, 1'b0, g);
		chk(g, 3'b010, "ud unsupported");
		fw.sect(2'h0, B0, Z0, f);
		fw.sect(2'h1, B1, Z1, f);
		chk({f, sect_count_q}, 4'h2, "section count");
		fw.query(1'b0, LEAF_ENCLAVE, SUBLEAF_SECT_FIRST, r);
		chk(r, '0, "sections hidden");
		// a write while the enable is low must leave no trace
		fw.enable(1'b0);
		fw.msr(1'b0, 32'h0004_0001, f);
		chk({f, opted_in_q}, 3'b000, "write while frozen");
		fw.enable(1'b1);
		fw.msr(1'b0, 32'h0004_0000, f);
		chk({f, opted_in_q}, 3'b000, "opt-in without lock");
		fw.instr(1'b0, 1'b0, g);
		chk(g, 3'b001, "gp without lock");
		fw.msr(1'b0, 32'h0004_0001, f);
		chk({f, opted_in_q}, 3'b001, "opted in");
		fw.instr(1'b0, 1'b0, g);
		chk(g, 3'b100, "instr runs");
		fw.instr(1'b0, 1'b1, g);
		chk(g, 3'b010, "extra ud");
		fw.msr(1'b0, 32'h0, f);
		chk({f, opted_in_q}, 3'b101, "locked write");
		fw.sect(2'h2, B0, Z0, f);
		chk({f, sect_count_q}, 4'ha, "sections frozen");
		fw.msr(1'b1, 32'h0004_0001, f);
		chk({f, opted_in_q}, 3'b101, "opt-in unsupported");
		chk_cap();
		fw.walk(1'b0, n);
		chk(n, 2, "walk count");
		fw.query(1'b0, LEAF_ENCLAVE, SUBLEAF_SECT_FIRST, r);
		chk(r, sx(B0, Z0), "section 0");
		fw.query(1'b0, LEAF_ENCLAVE, 32'h3, r);
		chk(r, sx(B1, Z1), "section 1");
		fw.query(1'b0, LEAF_ENCLAVE, 32'h4, r);
		chk(r, '0, "invalid sub-leaf");
		fw.query(1'b1, LEAF_ENCLAVE, 32'h3, r);
		chk(r, '0, "thread not opted");
		close_out();
	end
endmodule : testbench
